// *** hdl/r2t_regs.sv ***
`include "r2t_consts.svh"
`default_nettype none
// Rail 2 timing registers and power sequencer
module r2t_regs
  import r2t_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_err,
  input wire logic init_done,
  input wire logic enable_pin,
  input wire logic operation_on,
  input wire logic ref_move_up,
  input wire logic ref_move_dn,
  input wire logic readback_select,
  input wire logic [8:0] rail1_sense,
  input wire logic [8:0] rail2_sense,
  output logic [8:0] switch_freq,
  output logic ref_step_up,
  output logic ref_step_dn,
  output logic soft_start,
  output logic rail_on,
  output logic [2:0] seq_state
);
  // Every register of this module outside the tick and sense instances
  // lives in this one struct, so the next-state logic stays in a single process and nothing latches
  typedef struct packed {
    // Host-visible words, reserved bits already cleared
    logic [15:0] freq;
    logic [15:0] ton;
    logic [15:0] rise;
    logic [15:0] toff;
    logic [15:0] fall;
    // Snapshots taken as a sequence starts, so host writes wait their turn
    logic [15:0] ton_act;
    logic [15:0] toff_act;
    logic [10:0] rise_act;
    logic [10:0] fall_act;
    // Down counters for delays and step pacing
    logic [15:0] dly_cnt;
    logic [11:0] step_cnt;
    r2t_state_t state;
    // Two flip-flop synchronisers for the pin levels
    logic en_a;
    logic en_b;
    logic op_a;
    logic op_b;
    logic up_a;
    logic up_b;
    logic dn_a;
    logic dn_b;
    logic ini_a;
    logic ini_b;
    // Read answer and its one-cycle strobes
    logic [15:0] rdata;
    logic rvalid;
    logic err;
    // Registered copies of the outputs
    logic [8:0] freq_out;
    logic sup;
    logic sdn;
    logic ss;
    logic on;
    // Restarts the slow divider in the cycle a delay is loaded
    logic dly_clr;
  } r2t_st_t;
  r2t_st_t st, next_st;
  // Enable pulses from the divider
  logic t100;
  logic t50;
  // Selected and synchronised sense word
  logic [8:0] vout_value;
  // Decoded sequencer conditions
  logic run_req;
  logic dly_done;
  logic step_done;

  // Decode of readable offsets for the read error flag
  function automatic logic is_mapped(input logic [7:0] c);
    is_mapped = (c == `R2T_OFS_FREQ) || (c == `R2T_OFS_TON_DLY) || (c == `R2T_OFS_RISE) ||
      (c == `R2T_OFS_TOFF_DLY) || (c == `R2T_OFS_FALL) || (c == `R2T_OFS_VOUT);
  endfunction

  // The slow enable restarts at every delay load, so no delay is cut short
  // by a divider phase left over from earlier traffic
  r2t_tick u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .dly_restart(st.dly_clr),
    .tick_100us(t100),
    .tick_50ns(t50)
  );

  // Sense words and the rail selection
  r2t_vsense u_vsense (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .rail1_sense(rail1_sense),
    .rail2_sense(rail2_sense),
    .readback_select(readback_select),
    .vout_value(vout_value)
  );

  // Request to run comes from both pin and operation command
  assign run_req = st.en_b && st.op_b;
  // A delay of zero counts finishes at once
  assign dly_done = (st.dly_cnt == 16'h0);
  assign step_done = (st.step_cnt == 12'h0);

  // Register access, synchronisers and sequencer
  always_comb begin
    next_st = st;
    // Pin levels pass two flip-flops before any logic reads them
    next_st.en_a = enable_pin;
    next_st.en_b = st.en_a;
    next_st.op_a = operation_on;
    next_st.op_b = st.op_a;
    next_st.up_a = ref_move_up;
    next_st.up_b = st.up_a;
    next_st.dn_a = ref_move_dn;
    next_st.dn_b = st.dn_a;
    next_st.ini_a = init_done;
    next_st.ini_b = st.ini_a;
    // Strobes default low every cycle
    next_st.rvalid = 1'b0;
    next_st.err = 1'b0;
    next_st.sup = 1'b0;
    next_st.sdn = 1'b0;
    next_st.dly_clr = 1'b0;
    // Writes: reserved bits are masked away on the way in
    if (cmd_wr) begin
      if (cmd_code == `R2T_OFS_FREQ) begin
        next_st.freq = cmd_wdata & `R2T_FREQ_MASK;
      end else if (cmd_code == `R2T_OFS_TON_DLY) begin
        // Delay words keep all sixteen bits
        next_st.ton = cmd_wdata;
      end else if (cmd_code == `R2T_OFS_RISE) begin
        // Slew words keep only the eleven-bit count
        next_st.rise = cmd_wdata & `R2T_SLEW_MASK;
      end else if (cmd_code == `R2T_OFS_TOFF_DLY) begin
        next_st.toff = cmd_wdata;
      end else if (cmd_code == `R2T_OFS_FALL) begin
        next_st.fall = cmd_wdata & `R2T_SLEW_MASK;
      end else begin
        // Readback and unmapped codes ignore writes
        next_st.err = 1'b1;
      end
    end
    // Reads answer one cycle later; unmapped reads give zero with error
    if (cmd_rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = 16'h0000;
      if (cmd_code == `R2T_OFS_FREQ) begin
        next_st.rdata = st.freq;
      end else if (cmd_code == `R2T_OFS_TON_DLY) begin
        next_st.rdata = st.ton;
      end else if (cmd_code == `R2T_OFS_RISE) begin
        next_st.rdata = st.rise;
      end else if (cmd_code == `R2T_OFS_TOFF_DLY) begin
        next_st.rdata = st.toff;
      end else if (cmd_code == `R2T_OFS_FALL) begin
        next_st.rdata = st.fall;
      end else if (cmd_code == `R2T_OFS_VOUT) begin
        next_st.rdata = {7'h00, vout_value};
      end
      if (!is_mapped(cmd_code)) begin
        next_st.err = 1'b1;
      end
    end
    // Frequency follows the register one cycle later; it steers no sequence
    next_st.freq_out = st.freq[8:0];
    // Step pacing counter runs on the 50 ns enable
    if (t50 && !step_done) begin
      next_st.step_cnt = st.step_cnt - 12'h1;
    end
    // Delay counter runs on the 100 us enable; the load cycle skips a stale pulse
    if (t100 && !dly_done && !st.dly_clr) begin
      next_st.dly_cnt = st.dly_cnt - 16'h1;
    end
    // Power sequencer
    case (st.state)
      R2T_OFF: begin
        next_st.on = 1'b0;
        next_st.ss = 1'b0;
        // Wait until initialisation ends and both run inputs are high
        if (st.ini_b && run_req) begin
          next_st.ton_act = st.ton;
          next_st.rise_act = st.rise[10:0];
          next_st.fall_act = st.fall[10:0];
          next_st.toff_act = st.toff;
          next_st.dly_cnt = st.ton;
          next_st.dly_clr = 1'b1;
          next_st.state = R2T_ON_DLY;
        end
      end
      R2T_ON_DLY: begin
        // Dropping a run input aborts the delay quietly
        if (!run_req) begin
          next_st.state = R2T_OFF;
        end else if (dly_done) begin
          next_st.ss = 1'b1;
          next_st.step_cnt = {1'b0, st.rise_act} + 12'(`R2T_STEP_EXTRA);
          next_st.state = R2T_RAMP_UP;
        end
      end
      R2T_RAMP_UP: begin
        if (!run_req) begin
          // Soft-off during the ramp still honours the power-off delay
          next_st.ss = 1'b0;
          next_st.toff_act = st.toff;
          next_st.dly_cnt = st.toff;
          next_st.dly_clr = 1'b1;
          next_st.state = R2T_OFF_DLY;
        // Ramp ends when the reference stops rising
        end else if (!st.up_b) begin
          next_st.ss = 1'b0;
          next_st.on = 1'b1;
          next_st.state = R2T_ON;
        end else if (step_done) begin
          next_st.sup = 1'b1;
          next_st.step_cnt = {1'b0, st.rise_act} + 12'(`R2T_STEP_EXTRA);
        end
      end
      R2T_ON: begin
        if (!run_req) begin
          next_st.toff_act = st.toff;
          next_st.dly_cnt = st.toff;
          next_st.fall_act = st.fall[10:0];
          next_st.dly_clr = 1'b1;
          next_st.state = R2T_OFF_DLY;
        // Margin moves pace with the live slew words
        end else if (step_done && st.up_b) begin
          next_st.sup = 1'b1;
          next_st.step_cnt = {1'b0, st.rise[10:0]} + 12'(`R2T_STEP_EXTRA);
        end else if (step_done && st.dn_b) begin
          next_st.sdn = 1'b1;
          next_st.step_cnt = {1'b0, st.fall[10:0]} + 12'(`R2T_STEP_EXTRA);
        end
      end
      // Falling ramp starts once the power-off delay runs out
      R2T_OFF_DLY: begin
        if (dly_done) begin
          next_st.step_cnt = {1'b0, st.fall_act} + 12'(`R2T_STEP_EXTRA);
          next_st.state = R2T_RAMP_DN;
        end
      end
      // Rail is off once the reference stops falling
      R2T_RAMP_DN: begin
        if (!st.dn_b) begin
          next_st.on = 1'b0;
          next_st.state = R2T_OFF;
        end else if (step_done) begin
          next_st.sdn = 1'b1;
          next_st.step_cnt = {1'b0, st.fall_act} + 12'(`R2T_STEP_EXTRA);
        end
      end
      // Unused codes fall back to off
      default: begin
        next_st.state = R2T_OFF;
      end
    endcase
  end

  // State register with reset values
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
      st.freq <= `R2T_RST_FREQ;
      st.ton <= `R2T_RST_DLY;
      st.toff <= `R2T_RST_DLY;
      st.rise <= `R2T_RST_SLEW;
      st.fall <= `R2T_RST_SLEW;
      st.state <= R2T_OFF;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign cmd_rdata = st.rdata;
  assign cmd_rvalid = st.rvalid;
  assign cmd_err = st.err;
  assign switch_freq = st.freq_out;
  assign ref_step_up = st.sup;
  assign ref_step_dn = st.sdn;
  assign soft_start = st.ss;
  assign rail_on = st.on;
  assign seq_state = st.state;
endmodule
`default_nettype wire

// *** hdl/r2t_tick.sv ***
`include "r2t_consts.svh"
`default_nettype none
// Divider giving one-cycle enable pulses every 100 us and every 50 ns
module r2t_tick
  import r2t_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic dly_restart,
  output logic tick_100us,
  output logic tick_50ns
);
  typedef struct packed {
    logic [13:0] slow;
    logic [2:0] fast;
    logic slow_p;
    logic fast_p;
  } r2t_tick_st_t;
  r2t_tick_st_t st, next_st;

  // Counters with terminal pulses; the slow one restarts on a delay load
  always_comb begin
    next_st = st;
    next_st.slow_p = 1'b0;
    next_st.fast_p = 1'b0;
    // Restart keeps the next slow pulse one full period away from a load
    if (dly_restart) begin
      next_st.slow = 14'h0;
    end else if (st.slow == 14'(`R2T_TICK_CYC - 1)) begin
      next_st.slow = 14'h0;
      next_st.slow_p = 1'b1;
    end else begin
      next_st.slow = st.slow + 14'h1;
    end
    if (st.fast == 3'(`R2T_STEP_CYC - 1)) begin
      next_st.fast = 3'h0;
      next_st.fast_p = 1'b1;
    end else begin
      next_st.fast = st.fast + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_100us = st.slow_p;
  assign tick_50ns = st.fast_p;
endmodule
`default_nettype wire

// *** hdl/r2t_vsense.sv ***
`include "r2t_consts.svh"
`default_nettype none
// Synchronises both sensed rail voltages and picks one for readback
module r2t_vsense
  import r2t_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [8:0] rail1_sense,
  input wire logic [8:0] rail2_sense,
  input wire logic readback_select,
  output logic [8:0] vout_value
);
  typedef struct packed {
    logic [8:0] r1_a;
    logic [8:0] r1_b;
    logic [8:0] r2_a;
    logic [8:0] r2_b;
    logic sel_a;
    logic sel_b;
    // Third sample and accepted words for the stability filter
    logic [8:0] r1_c;
    logic [8:0] r2_c;
    logic [8:0] r1_hold;
    logic [8:0] r2_hold;
    logic [8:0] value;
  } r2t_vs_st_t;
  r2t_vs_st_t st, next_st;

  // Two stage sync; the second stage feeds the stability filter, whose held words feed the mux
  always_comb begin
    next_st = st;
    next_st.r1_a = rail1_sense;
    next_st.r1_b = st.r1_a;
    next_st.r2_a = rail2_sense;
    next_st.r2_b = st.r2_a;
    next_st.sel_a = readback_select;
    next_st.sel_b = st.sel_a;
    next_st.r1_c = st.r1_b;
    next_st.r2_c = st.r2_b;
    // A word is taken only after it held still for two samples, so bits
    // that settle at different edges never mix into one reading
    if (st.r1_b == st.r1_c) begin
      next_st.r1_hold = st.r1_b;
    end
    if (st.r2_b == st.r2_c) begin
      next_st.r2_hold = st.r2_b;
    end
    next_st.value = st.sel_b ? st.r1_hold : st.r2_hold;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign vout_value = st.value;
endmodule
`default_nettype wire

// *** include/r2t_consts.svh ***
// Overview of operation
// - Reserved bits ignore writes, read zero
// - Frequency: nine bits, 10 kHz per count
// - Power-on delay 16 bits, 100 us steps
// - Soft start only after delay expires
// - Rise count paces soft-start, margin-high
// - Each step lasts (count+3) times 50 ns
// - Power-off delay only at soft-off
// - Fall count paces soft-off, margin-low
// - Readback nine bits, 6.25 mV per count
// - Select bit picks rail 1 or 2
`ifndef R2T_CONSTS_SVH
`define R2T_CONSTS_SVH
`define R2T_OFS_FREQ 8'h33
`define R2T_OFS_TON_DLY 8'h60
`define R2T_OFS_RISE 8'h61
`define R2T_OFS_TOFF_DLY 8'h64
`define R2T_OFS_FALL 8'h65
`define R2T_OFS_VOUT 8'h8B
`define R2T_FREQ_MASK 16'h01FF
`define R2T_SLEW_MASK 16'h07FF
`define R2T_VOUT_MASK 16'h01FF
`define R2T_RST_FREQ 16'h0032
`define R2T_RST_DLY 16'h0000
`define R2T_RST_SLEW 16'h0000
`define R2T_CLK_NS 10
`define R2T_TICK_US 100
`define R2T_TICK_CYC ((`R2T_TICK_US * 1000) / `R2T_CLK_NS)
`define R2T_STEP_NS 50
`define R2T_STEP_CYC (`R2T_STEP_NS / `R2T_CLK_NS)
`define R2T_STEP_EXTRA 3
`endif

// *** include/r2t_pkg.sv ***
package r2t_pkg;
  // Sequencer states, Gray coded along off->delay->ramp->on->off-delay->fall
  typedef enum logic [2:0] {
    R2T_OFF = 3'b000,
    R2T_ON_DLY = 3'b001,
    R2T_RAMP_UP = 3'b011,
    R2T_ON = 3'b010,
    R2T_OFF_DLY = 3'b110,
    R2T_RAMP_DN = 3'b111
  } r2t_state_t;
endpackage

// *** tb/r2t_assertions.sv ***
`default_nettype none
// Port-level checks on the rail 2 timing block
module r2t_assertions
  import r2t_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_err,
  input wire logic [8:0] switch_freq,
  input wire logic ref_step_up,
  input wire logic ref_step_dn,
  input wire logic soft_start,
  input wire logic [2:0] seq_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  property p_rd_ans;
    cmd_rd |=> cmd_rvalid || cmd_err;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_spur;
    !cmd_rd |=> !cmd_rvalid;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("answer without read");
  property p_rsv_freq;
    cmd_rvalid && $past(cmd_code) == 8'h33 |-> cmd_rdata[15:9] == 7'h00;
  endproperty
  a_rsv_freq: assert property (p_rsv_freq) else $error("frequency upper bits set");
  property p_rsv_slew;
    cmd_rvalid && $past(cmd_code) inside {8'h61, 8'h65} |-> cmd_rdata[15:11] == 5'h00;
  endproperty
  a_rsv_slew: assert property (p_rsv_slew) else $error("slew upper bits set");
  property p_rsv_vout;
    cmd_rvalid && $past(cmd_code) == 8'h8B |-> cmd_rdata[15:9] == 7'h00;
  endproperty
  a_rsv_vout: assert property (p_rsv_vout) else $error("readback upper bits set");
  property p_freq_chg;
    $changed(switch_freq) && !$past(sys_rst) && !$past(sys_rst, 2) |->
      $past(cmd_wr && cmd_code == 8'h33) || $past(cmd_wr && cmd_code == 8'h33, 2);
  endproperty
  a_freq_chg: assert property (p_freq_chg) else $error("frequency moved unasked");
  property p_ss_after;
    $rose(soft_start) |-> $past(seq_state) == R2T_ON_DLY || $past(seq_state, 2) == R2T_ON_DLY;
  endproperty
  a_ss_after: assert property (p_ss_after) else $error("soft start without delay");
  property p_step_gap;
    ref_step_up |=> !ref_step_up [*8];
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("rise steps too close");
  property p_dn_ramp;
    ref_step_dn |-> !soft_start;
  endproperty
  a_dn_ramp: assert property (p_dn_ramp) else $error("down step in soft start");
endmodule
bind r2t_regs r2t_assertions u_chk (.mclk(mclk), .sys_rst(sys_rst), .cmd_wr(cmd_wr),
  .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
  .cmd_err(cmd_err), .switch_freq(switch_freq), .ref_step_up(ref_step_up),
  .ref_step_dn(ref_step_dn), .soft_start(soft_start), .seq_state(seq_state));
`default_nettype wire

// *** tb/r2t_host.sv ***
`default_nettype none
// Command host: one-cycle strobes launched on the falling edge
module r2t_host (
  input wire logic mclk,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_err,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Write one word; slew words ending in five ones go out with bit 0 cleared
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge mclk);
    if ((c == 8'h61 || c == 8'h65) && d[4:0] == 5'h1F) d[0] = 1'b0;
    cmd_code = c;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(negedge mclk);
    cmd_wr = 1'b0;
    // Stale data would hide a late capture
    cmd_wdata = ~d;
  endtask
  // Read; the answer pulse lasts one cycle, so poll every cycle
  task automatic rd(input logic [7:0] c, output logic [15:0] q, output logic e);
    int n;
    q = 'x;
    e = 1'b0;
    @(negedge mclk);
    cmd_code = c;
    cmd_rd = 1'b1;
    @(negedge mclk);
    cmd_rd = 1'b0;
    for (n = 0; n < 3; n++) begin
      if (cmd_rvalid === 1'b1 || cmd_err === 1'b1) begin
        q = cmd_rdata;
        e = cmd_err;
        break;
      end
      @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import r2t_pkg::*;
  logic mclk, sys_rst, cmd_wr, cmd_rd, cmd_rvalid, cmd_err, init_done, enable_pin;
  logic operation_on, ref_move_up, ref_move_dn, readback_select;
  logic ref_step_up, ref_step_dn, soft_start, rail_on;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata;
  logic [8:0] rail1_sense, rail2_sense, switch_freq;
  logic [2:0] seq_state;
  int errors = 0;
  int tests_run = 0;
  r2t_host host (.mclk(mclk), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .cmd_err(cmd_err), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata));
  r2t_regs DUT (.mclk(mclk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .cmd_err(cmd_err), .init_done(init_done),
    .enable_pin(enable_pin), .operation_on(operation_on), .ref_move_up(ref_move_up),
    .ref_move_dn(ref_move_dn), .readback_select(readback_select),
    .rail1_sense(rail1_sense), .rail2_sense(rail2_sense), .switch_freq(switch_freq),
    .ref_step_up(ref_step_up), .ref_step_dn(ref_step_dn), .soft_start(soft_start),
    .rail_on(rail_on), .seq_state(seq_state));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Counts cycles up to the next step pulse, bounded
  task automatic wait_pulse(input logic up, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((up ? ref_step_up : ref_step_dn) !== 1'b1 && n < 200);
  endtask
  // Counts cycles until the sequencer reaches a state
  task automatic wait_state(input logic [2:0] s, output int n);
    n = 0;
    while (seq_state !== s && n < 30000) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic t_regs;
    logic [7:0] code [5] = '{8'h33, 8'h60, 8'h61, 8'h64, 8'h65};
    logic [15:0] msk [5] = '{16'h01FF, 16'hFFFF, 16'h07FF, 16'hFFFF, 16'h07FF};
    logic [15:0] q;
    logic e;
    for (int i = 0; i < 5; i++) begin
      host.rd(code[i], q, e);
      chk("reset value", q, i == 0 ? 16'h0032 : 16'h0000);
      host.wr(code[i], 16'hFFDE);
      host.rd(code[i], q, e);
      chk("masked value", q, 16'hFFDE & msk[i]);
    end
    chk("frequency out", {7'h00, switch_freq}, 16'h01DE);
    host.rd(8'h34, q, e);
    chk("unmapped flag", {15'h0, e}, 16'h0001);
    $display("test regs done");
  endtask
  task automatic t_vout;
    logic [15:0] q;
    logic e;
    host.wr(8'h8B, 16'hFFFF);
    rail1_sense = 9'h155;
    rail2_sense = 9'h0AA;
    for (int s = 0; s < 2; s++) begin
      readback_select = s[0];
      // Two-stage input sync needs a few cycles
      repeat (6) @(negedge mclk);
      host.rd(8'h8B, q, e);
      chk("voltage readback", q, s == 1 ? 16'h0155 : 16'h00AA);
    end
    $display("test vout done");
  endtask
  task automatic t_seq;
    int n;
    host.wr(8'h60, 16'h0001);
    host.wr(8'h61, 16'h0002);
    host.wr(8'h64, 16'h0001);
    host.wr(8'h65, 16'h0000);
    @(negedge mclk);
    {init_done, enable_pin, operation_on, ref_move_up} = 4'hF;
    wait_state(R2T_RAMP_UP, n);
    chk("on delay", 16'(n >= 10000 && n <= 20010 && soft_start === 1'b1), 16'h0001);
    wait_pulse(1'b1, n);
    host.wr(8'h61, 16'h0004);
    wait_pulse(1'b1, n);
    wait_pulse(1'b1, n);
    chk("rise step gap", n[15:0], 16'h0019);
    ref_move_up = 1'b0;
    repeat (6) @(negedge mclk);
    chk("state on", {13'h0, seq_state}, {13'h0, R2T_ON});
    chk("rail on", {15'h0, rail_on}, 16'h0001);
    // Margin move in the on state paces with the live rise word
    ref_move_up = 1'b1;
    wait_pulse(1'b1, n);
    wait_pulse(1'b1, n);
    chk("margin step gap", n[15:0], 16'h0023);
    ref_move_up = 1'b0;
    repeat (6) @(negedge mclk);
    {operation_on, ref_move_dn} = 2'b01;
    wait_state(R2T_RAMP_DN, n);
    chk("off delay", 16'(n >= 10000 && n <= 20010), 16'h0001);
    wait_pulse(1'b0, n);
    wait_pulse(1'b0, n);
    chk("fall step gap", n[15:0], 16'h000F);
    ref_move_dn = 1'b0;
    repeat (6) @(negedge mclk);
    chk("state off", {13'h0, seq_state}, {13'h0, R2T_OFF});
    chk("rail off", {15'h0, rail_on}, 16'h0000);
    $display("test sequence done");
  endtask
  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Two full delays fit well inside this span
  initial begin
    #600us;
    errors++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1;
    {init_done, enable_pin, operation_on, ref_move_up, ref_move_dn, readback_select} = 6'h00;
    rail1_sense = 9'h000;
    rail2_sense = 9'h000;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    t_regs();
    t_vout();
    t_seq();
    report_and_stop();
  end
endmodule
`default_nettype wire
